// ### pkg/ofch_pkg.sv
package ofch_pkg;
   // function number of the host controller
   localparam logic [2:0]  FUNC_NUM    = 3'h2;
   // dword byte offsets
   localparam logic [7:0]  OFS_IDENT   = 8'h00;
   localparam logic [7:0]  OFS_CMD     = 8'h04;
   localparam logic [7:0]  OFS_CLASS   = 8'h08;
   localparam logic [7:0]  OFS_CACHE   = 8'h0c;
   localparam logic [7:0]  OFS_BAR0    = 8'h10;
   localparam logic [7:0]  OFS_BAR1    = 8'h14;
   localparam logic [7:0]  OFS_BAR2    = 8'h18;
   localparam logic [7:0]  OFS_CIS     = 8'h28;
   localparam logic [7:0]  OFS_SUBSYS  = 8'h2c;
   localparam logic [7:0]  OFS_CAPPTR  = 8'h34;
   localparam logic [7:0]  OFS_INTR    = 8'h3c;
   localparam logic [7:0]  OFS_HCCTL   = 8'h40;
   localparam logic [7:0]  OFS_PMCAP   = 8'h44;
   localparam logic [7:0]  OFS_PMCSR   = 8'h48;
   localparam logic [7:0]  OFS_RSVD_LO = 8'h4c;
   localparam logic [7:0]  OFS_PHY     = 8'hec;
   localparam logic [7:0]  OFS_MISC    = 8'hf0;
   localparam logic [7:0]  OFS_LINK    = 8'hf4;
   localparam logic [7:0]  OFS_SSACC   = 8'hf8;
   // writable bit masks
   localparam logic [31:0] CMD_WMASK   = 32'h0000_0156;
   localparam logic [31:0] CACHE_WMASK = 32'h0000_ffff;
   localparam logic [31:0] INTL_WMASK  = 32'h0000_00ff;
   localparam logic [31:0] LAT_WMASK   = 32'hffff_0000;
   localparam logic [31:0] PMCSR_WMASK = 32'h0000_0103;
   localparam logic [31:0] FULL_WMASK  = 32'hffff_ffff;
   // values after reset
   localparam logic [31:0] CMD_RST     = 32'h0000_0000;
   localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
   localparam logic [31:0] LAT_RST     = 32'h0000_0000;
   localparam logic [31:0] PMCSR_RST   = 32'h0000_0000;
   // fixed fields
   localparam logic [15:0] STATUS_VAL  = 16'h0210;
   localparam logic [7:0]  HDR_TYPE    = 8'h80;
   localparam logic [7:0]  CAP_PTR     = 8'h44;
   localparam logic [7:0]  CAP_ID_PM   = 8'h01;
   localparam logic [7:0]  CAP_NEXT    = 8'h00;
endpackage

// ### verilog/ofch_top.sv
`timescale 1ns/1ps
// Operation
// - answer only as function two, standard header
// - sticky bits cleared by global reset only
// - sticky context survives warm resets
// - read-only maker code at 00h
// - read-only part code at 02h, writes ignored
// - command bits 8,6,4,2,1 writable, reset zero
// - decode standard header dwords through 3Ch
module ofch_top
   import ofch_pkg::*;
#(
   parameter logic [15:0] MAKER_ID   = 16'h1234,   // arbitrary value
   parameter logic [15:0] PART_ID    = 16'h5678,   // arbitrary value
   parameter logic [7:0]  REVISION   = 8'h00,
   parameter logic [23:0] CLASS_CODE = 24'h0c0010,
   parameter logic [7:0]  INT_PIN    = 8'h01,
   parameter logic [15:0] PM_CAPS    = 16'h0002,
   parameter logic [31:0] HCC_WMASK  = 32'hffff_ffff,
   parameter int          BAR0_BITS  = 11,
   parameter int          BAR1_BITS  = 14,
   parameter int          BAR2_BITS  = 12
) (
   // clock and resets
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        GLOBAL_RESET_INPUT,
   // configuration access
   input  wire logic        CFG_REQ,
   input  wire logic        CFG_WR,
   input  wire logic [2:0]  CFG_FUNC,
   input  wire logic [7:0]  CFG_ADDR,
   input  wire logic [3:0]  CFG_BE,
   input  wire logic [31:0] CFG_WDATA,
   output logic             CFG_ACK,
   output logic [31:0]      CFG_RDATA,
   // controls to the function
   output logic [15:0]      BUS_COMMAND,
   output logic [31:0]      HC_CONTROL,
   output logic [1:0]       POWER_STATE,
   output logic [31:0]      MULTIFUNCTION_TERMINAL_CONFIG,
   output logic [31:0]      LINK_ENHANCEMENT,
   output logic [31:0]      PHY_ACCESS_CONTROL
);

   localparam logic [31:0] BAR0_MASK = 32'hffff_ffff << BAR0_BITS;
   localparam logic [31:0] BAR1_MASK = 32'hffff_ffff << BAR1_BITS;
   localparam logic [31:0] BAR2_MASK = 32'hffff_ffff << BAR2_BITS;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] m);
      logic [31:0] bm;
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
      return (old & ~bm) | (wd & bm);
   endfunction

   logic        global_reset_input_m;
   logic        global_reset_input_s;
   logic        rst_any;
   logic [5:0]  cidx;
   logic        hit;
   logic        wr;
   logic        rd;
   logic [31:0] rd_mux;
   logic        ack_q;
   logic [31:0] rdata_q;
   // ordinary registers
   logic [31:0] cmd_q,  cmd_d;
   logic [31:0] cache_q, cache_d;
   logic [31:0] bar0_q, bar0_d;
   logic [31:0] bar1_q, bar1_d;
   logic [31:0] bar2_q, bar2_d;
   logic [31:0] intl_q, intl_d;
   logic [31:0] hcc_q,  hcc_d;
   // sticky registers
   logic [31:0] cis_q,  cis_d;
   logic [31:0] ss_q,   ss_d;
   logic [31:0] lat_q,  lat_d;
   logic [31:0] pm_q,   pm_d;
   logic [31:0] phy_q,  phy_d;
   logic [31:0] misc_q, misc_d;
   logic [31:0] link_q, link_d;

   // global reset pin synchroniser
   always_ff @(posedge CLK_SYS) begin
      global_reset_input_m <= GLOBAL_RESET_INPUT;
      global_reset_input_s <= global_reset_input_m;
   end

   assign rst_any = SYS_RST | global_reset_input_s;
   assign cidx    = CFG_ADDR[7:2];
   assign hit     = CFG_REQ && (CFG_FUNC == FUNC_NUM);
   assign wr      = hit && CFG_WR && !rst_any;
   assign rd      = hit && !CFG_WR && !rst_any;

   // write paths; the identification dwords have none
   assign cmd_d   = (wr && cidx == OFS_CMD[7:2])    ? wmerge(cmd_q, CFG_WDATA, CFG_BE, CMD_WMASK)     : cmd_q;
   assign cache_d = (wr && cidx == OFS_CACHE[7:2])  ? wmerge(cache_q, CFG_WDATA, CFG_BE, CACHE_WMASK) : cache_q;
   assign bar0_d  = (wr && cidx == OFS_BAR0[7:2])   ? wmerge(bar0_q, CFG_WDATA, CFG_BE, BAR0_MASK)    : bar0_q;
   assign bar1_d  = (wr && cidx == OFS_BAR1[7:2])   ? wmerge(bar1_q, CFG_WDATA, CFG_BE, BAR1_MASK)    : bar1_q;
   assign bar2_d  = (wr && cidx == OFS_BAR2[7:2])   ? wmerge(bar2_q, CFG_WDATA, CFG_BE, BAR2_MASK)    : bar2_q;
   assign intl_d  = (wr && cidx == OFS_INTR[7:2])   ? wmerge(intl_q, CFG_WDATA, CFG_BE, INTL_WMASK)   : intl_q;
   assign hcc_d   = (wr && cidx == OFS_HCCTL[7:2])  ? wmerge(hcc_q, CFG_WDATA, CFG_BE, HCC_WMASK)     : hcc_q;
   assign cis_d   = (wr && cidx == OFS_CIS[7:2])    ? wmerge(cis_q, CFG_WDATA, CFG_BE, FULL_WMASK)    : cis_q;
   assign lat_d   = (wr && cidx == OFS_INTR[7:2])   ? wmerge(lat_q, CFG_WDATA, CFG_BE, LAT_WMASK)     : lat_q;
   assign pm_d    = (wr && cidx == OFS_PMCSR[7:2])  ? wmerge(pm_q, CFG_WDATA, CFG_BE, PMCSR_WMASK)    : pm_q;
   assign phy_d   = (wr && cidx == OFS_PHY[7:2])    ? wmerge(phy_q, CFG_WDATA, CFG_BE, FULL_WMASK)    : phy_q;
   assign misc_d  = (wr && cidx == OFS_MISC[7:2])   ? wmerge(misc_q, CFG_WDATA, CFG_BE, FULL_WMASK)   : misc_q;
   assign link_d  = (wr && cidx == OFS_LINK[7:2])   ? wmerge(link_q, CFG_WDATA, CFG_BE, FULL_WMASK)   : link_q;
   // subsystem words load only through the access dword
   assign ss_d    = (wr && cidx == OFS_SSACC[7:2])  ? wmerge(ss_q, CFG_WDATA, CFG_BE, FULL_WMASK)     : ss_q;

   // read decode; anything unmatched reads zero
   always_comb begin
      rd_mux = ZERO_RST;
      if (cidx == OFS_IDENT[7:2]) begin
         rd_mux = {PART_ID, MAKER_ID};
      end else if (cidx == OFS_CMD[7:2]) begin
         rd_mux = {STATUS_VAL, cmd_q[15:0]};
      end else if (cidx == OFS_CLASS[7:2]) begin
         rd_mux = {CLASS_CODE, REVISION};
      end else if (cidx == OFS_CACHE[7:2]) begin
         rd_mux = {8'h00, HDR_TYPE, cache_q[15:0]};
      end else if (cidx == OFS_BAR0[7:2]) begin
         rd_mux = bar0_q;
      end else if (cidx == OFS_BAR1[7:2]) begin
         rd_mux = bar1_q;
      end else if (cidx == OFS_BAR2[7:2]) begin
         rd_mux = bar2_q;
      end else if (cidx == OFS_CIS[7:2]) begin
         rd_mux = cis_q;
      end else if (cidx == OFS_SUBSYS[7:2]) begin
         rd_mux = ss_q;
      end else if (cidx == OFS_CAPPTR[7:2]) begin
         rd_mux = {24'h000000, CAP_PTR};
      end else if (cidx == OFS_INTR[7:2]) begin
         rd_mux = {lat_q[31:16], INT_PIN, intl_q[7:0]};
      end else if (cidx == OFS_HCCTL[7:2]) begin
         rd_mux = hcc_q;
      end else if (cidx == OFS_PMCAP[7:2]) begin
         rd_mux = {PM_CAPS, CAP_NEXT, CAP_ID_PM};
      end else if (cidx == OFS_PMCSR[7:2]) begin
         rd_mux = pm_q;
      end else if (cidx == OFS_PHY[7:2]) begin
         rd_mux = phy_q;
      end else if (cidx == OFS_MISC[7:2]) begin
         rd_mux = misc_q;
      end else if (cidx == OFS_LINK[7:2]) begin
         rd_mux = link_q;
      end else if (cidx == OFS_SSACC[7:2]) begin
         rd_mux = ss_q;
      end
   end

   // bus answer
   always_ff @(posedge CLK_SYS) begin
      if (rst_any) begin
         ack_q   <= 1'b0;
         rdata_q <= ZERO_RST;
      end else begin
         ack_q   <= hit;
         rdata_q <= rd ? rd_mux : ZERO_RST;
      end
   end

   // ordinary registers, cleared by either reset
   always_ff @(posedge CLK_SYS) begin
      if (rst_any) begin
         cmd_q   <= CMD_RST;
         cache_q <= ZERO_RST;
         bar0_q  <= ZERO_RST;
         bar1_q  <= ZERO_RST;
         bar2_q  <= ZERO_RST;
         intl_q  <= ZERO_RST;
         hcc_q   <= ZERO_RST;
      end else begin
         cmd_q   <= cmd_d;
         cache_q <= cache_d;
         bar0_q  <= bar0_d;
         bar1_q  <= bar1_d;
         bar2_q  <= bar2_d;
         intl_q  <= intl_d;
         hcc_q   <= hcc_d;
      end
   end

   // sticky registers, cleared by the global reset alone
   always_ff @(posedge CLK_SYS) begin
      if (global_reset_input_s) begin
         cis_q  <= ZERO_RST;
         ss_q   <= ZERO_RST;
         lat_q  <= LAT_RST;
         pm_q   <= PMCSR_RST;
         phy_q  <= ZERO_RST;
         misc_q <= ZERO_RST;
         link_q <= ZERO_RST;
      end else begin
         cis_q  <= cis_d;
         ss_q   <= ss_d;
         lat_q  <= lat_d;
         pm_q   <= pm_d;
         phy_q  <= phy_d;
         misc_q <= misc_d;
         link_q <= link_d;
      end
   end

   assign CFG_ACK                       = ack_q;
   assign CFG_RDATA                     = rdata_q;
   assign BUS_COMMAND                   = cmd_q[15:0];
   assign HC_CONTROL                    = hcc_q;
   assign POWER_STATE                   = pm_q[1:0];
   assign MULTIFUNCTION_TERMINAL_CONFIG = misc_q;
   assign LINK_ENHANCEMENT              = link_q;
   assign PHY_ACCESS_CONTROL            = phy_q;

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (rst_any);

   sequence s_wr(logic [5:0] ix, logic [31:0] d);
      CFG_REQ && CFG_WR && CFG_FUNC == FUNC_NUM && cidx == ix && CFG_BE == 4'hf && CFG_WDATA == d;
   endsequence

   sequence s_rd(logic [5:0] ix);
      CFG_REQ && !CFG_WR && CFG_FUNC == FUNC_NUM && cidx == ix;
   endsequence

   // one idle bus cycle between a write and its readback
   sequence s_pause;
      !CFG_REQ;
   endsequence

   sequence s_foreign_wr;
      CFG_REQ && CFG_WR && CFG_FUNC != FUNC_NUM;
   endsequence

   sequence s_own_wr;
      CFG_REQ && CFG_WR && CFG_FUNC == FUNC_NUM;
   endsequence

   a_func_answer: assert property (hit |=> CFG_ACK)
      else $error("function two request not answered");
   a_func_foreign: assert property (CFG_REQ && !hit |=> !CFG_ACK)
      else $error("other function answered");
   a_sticky_hold: assert property (disable iff (global_reset_input_s || global_reset_input_m)
      SYS_RST |=> $stable(pm_q) && $stable(phy_q) && $stable(link_q) && $stable(cis_q))
      else $error("sticky bit lost on warm reset");
   a_sticky_clear: assert property (disable iff (1'b0)
      global_reset_input_s |=> misc_q == ZERO_RST && pm_q == PMCSR_RST && lat_q == LAT_RST && ss_q == ZERO_RST)
      else $error("global reset left sticky bit set");
   a_warm_context: assert property (disable iff (global_reset_input_s || global_reset_input_m)
      SYS_RST [*2] |=> $stable(misc_q) && $stable(ss_q) && $stable(lat_q))
      else $error("routing context lost on warm reset");
   a_maker_code: assert property (s_rd(OFS_IDENT[7:2]) |=> CFG_RDATA[15:0] == MAKER_ID)
      else $error("maker code wrong");
   a_part_fixed: assert property (s_wr(OFS_IDENT[7:2], 32'hffff_ffff)
      ##1 s_pause ##1 s_rd(OFS_IDENT[7:2])
      |=> CFG_RDATA[31:16] == PART_ID)
      else $error("part code changed by write");
   a_cmd_mask: assert property (s_wr(OFS_CMD[7:2], 32'hffff_ffff)
      ##1 s_pause ##1 s_rd(OFS_CMD[7:2])
      |=> CFG_RDATA == {STATUS_VAL, CMD_WMASK[15:0]})
      else $error("command writable bits wrong");
   a_cmd_reset: assert property (disable iff (1'b0) rst_any |=> BUS_COMMAND == 16'h0000)
      else $error("command not zero after reset");
   a_bar_size: assert property (s_wr(OFS_BAR0[7:2], 32'hffff_ffff)
      ##1 s_pause ##1 s_rd(OFS_BAR0[7:2])
      |=> CFG_RDATA == BAR0_MASK)
      else $error("base address size mask wrong");
   a_subsys_load: assert property (s_wr(OFS_SSACC[7:2], 32'ha5a5_5a5a)
      ##1 s_pause ##1 s_rd(OFS_SUBSYS[7:2])
      |=> CFG_RDATA == 32'ha5a5_5a5a)
      else $error("subsystem access not reflected");
   a_cap_chain: assert property (s_rd(OFS_PMCAP[7:2]) |=> CFG_RDATA[15:0] == {CAP_NEXT, CAP_ID_PM})
      else $error("power capability header wrong");
   a_reserved_zero: assert property (s_wr(OFS_RSVD_LO[7:2], 32'hffff_ffff)
      ##1 s_pause ##1 s_rd(OFS_RSVD_LO[7:2])
      |=> CFG_RDATA == ZERO_RST)
      else $error("reserved dword not zero");

   // answer only follows a taken request
   a_ack_idle: assert property (!hit |=> !CFG_ACK)
      else $error("answer without request");

   a_rdata_idle: assert property (!rd |=> CFG_RDATA == ZERO_RST)
      else $error("read data outside read answer");

   a_write_quiet: assert property (s_own_wr |=> CFG_RDATA == ZERO_RST)
      else $error("read data on write answer");

   a_foreign_nowrite: assert property (s_foreign_wr
      |=> $stable(cmd_q) && $stable(hcc_q) && $stable(misc_q) && $stable(link_q))
      else $error("other function write landed");

   // read-only bits never set
   a_cmd_ro_bits: assert property ((BUS_COMMAND & ~CMD_WMASK[15:0]) == 16'h0000)
      else $error("command read-only bit set");

   a_pm_ro_bits: assert property ((pm_q & ~PMCSR_WMASK) == ZERO_RST)
      else $error("power control read-only bit set");

   a_bar_low: assert property ((bar0_q & ~BAR0_MASK) == ZERO_RST && (bar1_q & ~BAR1_MASK) == ZERO_RST
      && (bar2_q & ~BAR2_MASK) == ZERO_RST)
      else $error("base address low bits set");

   a_status_fixed: assert property (s_rd(OFS_CMD[7:2]) |=> CFG_RDATA[31:16] == STATUS_VAL)
      else $error("status word wrong");

   a_class_word: assert property (s_rd(OFS_CLASS[7:2]) |=> CFG_RDATA == {CLASS_CODE, REVISION})
      else $error("class and revision wrong");

   a_header_type: assert property (s_rd(OFS_CACHE[7:2]) |=> CFG_RDATA[31:16] == {8'h00, HDR_TYPE})
      else $error("header type wrong");

   a_cap_pointer: assert property (s_rd(OFS_CAPPTR[7:2]) |=> CFG_RDATA == {24'h000000, CAP_PTR})
      else $error("capability pointer wrong");

   // non-sticky words cleared by any reset; sticky phy, link and cis words cleared by the global reset
   a_hcc_reset: assert property (disable iff (1'b0) rst_any |=> HC_CONTROL == ZERO_RST)
      else $error("controller control not cleared");

   a_bar_reset: assert property (disable iff (1'b0) rst_any |=> bar0_q == ZERO_RST && intl_q == ZERO_RST)
      else $error("header word not cleared");

   a_phy_clear: assert property (disable iff (1'b0)
      global_reset_input_s |=> PHY_ACCESS_CONTROL == ZERO_RST && LINK_ENHANCEMENT == ZERO_RST && cis_q == ZERO_RST)
      else $error("global reset left link or phy set");

endmodule

// ### bench/ofch_host_model.sv
`timescale 1ns/1ps
module ofch_host_model (
   // bus clock
   input  wire logic        clk,
   // request side
   output logic             cfg_req,
   output logic             cfg_wr,
   output logic [2:0]       cfg_func,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata,
   // answer side
   input  wire logic        cfg_ack,
   input  wire logic [31:0] cfg_rdata
);
   initial begin
      cfg_req   = 1'b0;
      cfg_wr    = 1'b0;
      cfg_func  = 3'h0;
      cfg_addr  = 8'h00;
      cfg_be    = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // one access: request pulse, answer taken one cycle later
   task automatic access(input logic wr, input logic [2:0] fn, input logic [7:0] ad, input logic [3:0] be,
                         input logic [31:0] wd, output logic ak, output logic [31:0] rd);
      @(posedge clk);
      #1;
      cfg_req   = 1'b1;
      cfg_wr    = wr;
      cfg_func  = fn;
      cfg_addr  = ad;
      cfg_be    = be;
      cfg_wdata = wd;
      @(posedge clk);
      #1;
      cfg_req   = 1'b0;
      // released data, address and enable lines must not keep their last value
      cfg_wdata = ~wd;
      cfg_addr  = ~ad;
      cfg_be    = ~be;
      ak        = cfg_ack;
      rd        = cfg_rdata;
   endtask
endmodule

// ### bench/ofch_top_tb.sv
`timescale 1ns/1ps
module ofch_top_tb;
   typedef struct packed {logic w; logic [2:0] f; logic [7:0] a; logic [3:0] b; logic [31:0] d; logic k;
                          logic [31:0] r;} ofch_row_t;
   localparam logic [15:0] MAKER = 16'h1234;   // arbitrary value
   localparam logic [15:0] PART  = 16'h5678;   // arbitrary value
   logic clk_sys, sys_rst, global_reset_input, req, wr, ack;
   logic [2:0]  func;
   logic [7:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata, rdata, got_d, mft, lnk, phy, hcc;
   logic [15:0] cmd;
   logic [1:0]  pst;
   logic        got_k;
   int          mismatches, checks_done;
   ofch_row_t   rows [26] = '{
      '{0, 3'h2, 8'h00, 4'hf, 32'h0, 1, {PART, MAKER}},
      '{1, 3'h2, 8'h00, 4'hf, 32'hffff_ffff, 1, 32'h0},
      '{0, 3'h2, 8'h00, 4'hf, 32'h0, 1, {PART, MAKER}},
      '{1, 3'h2, 8'h04, 4'hf, 32'hffff_ffff, 1, 32'h0},
      '{0, 3'h2, 8'h04, 4'hf, 32'h0, 1, 32'h0210_0156},
      '{1, 3'h2, 8'h04, 4'h1, 32'h0, 1, 32'h0},
      '{0, 3'h2, 8'h04, 4'hf, 32'h0, 1, 32'h0210_0100},
      '{0, 3'h3, 8'h00, 4'hf, 32'h0, 0, 32'h0},
      '{1, 3'h1, 8'h04, 4'hf, 32'h0, 0, 32'h0},
      '{0, 3'h2, 8'h0c, 4'hf, 32'h0, 1, 32'h0080_0000},
      '{1, 3'h2, 8'h28, 4'hf, 32'h1234_5678, 1, 32'h0},
      '{0, 3'h2, 8'h28, 4'hf, 32'h0, 1, 32'h1234_5678},
      '{0, 3'h2, 8'h3c, 4'hf, 32'h0, 1, 32'h0000_0100},
      '{1, 3'h2, 8'h4c, 4'hf, 32'hffff_ffff, 1, 32'h0},
      '{0, 3'h2, 8'h4c, 4'hf, 32'h0, 1, 32'h0},
      '{1, 3'h2, 8'hf0, 4'hf, 32'ha5a5_a5a5, 1, 32'h0},
      '{1, 3'h2, 8'h40, 4'hf, 32'h0f0f_0f0f, 1, 32'h0},
      '{0, 3'h2, 8'h44, 4'hf, 32'h0, 1, 32'h0002_0001},
      '{1, 3'h2, 8'h10, 4'hf, 32'hffff_ffff, 1, 32'h0},
      '{0, 3'h2, 8'h10, 4'hf, 32'h0, 1, 32'hffff_f800},
      '{1, 3'h2, 8'hf8, 4'hf, 32'ha5a5_5a5a, 1, 32'h0},
      '{0, 3'h2, 8'h2c, 4'hf, 32'h0, 1, 32'ha5a5_5a5a},
      '{1, 3'h2, 8'hf4, 4'hf, 32'h3c3c_c3c3, 1, 32'h0},
      '{1, 3'h2, 8'hec, 4'hf, 32'h6969_9696, 1, 32'h0},
      '{1, 3'h2, 8'h48, 4'hf, 32'hffff_ffff, 1, 32'h0},
      '{0, 3'h2, 8'h48, 4'hf, 32'h0, 1, 32'h0000_0103}};
   ofch_top #(.MAKER_ID(MAKER), .PART_ID(PART)) ofch_top_i (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .GLOBAL_RESET_INPUT(global_reset_input), .CFG_REQ(req), .CFG_WR(wr),
      .CFG_FUNC(func), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_ACK(ack), .CFG_RDATA(rdata),
      .BUS_COMMAND(cmd), .HC_CONTROL(hcc), .POWER_STATE(pst), .MULTIFUNCTION_TERMINAL_CONFIG(mft),
      .LINK_ENHANCEMENT(lnk), .PHY_ACCESS_CONTROL(phy));
   ofch_host_model ofch_host_model_i (
      .clk(clk_sys), .cfg_req(req), .cfg_wr(wr), .cfg_func(func), .cfg_addr(addr), .cfg_be(be),
      .cfg_wdata(wdata), .cfg_ack(ack), .cfg_rdata(rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input bit glob, input int n);
      @(posedge clk_sys);
      #1;
      if (glob) global_reset_input = 1'b1; else sys_rst = 1'b1;
      repeat (n) @(posedge clk_sys);
      #1;
      global_reset_input    = 1'b0;
      sys_rst = 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic close_out();
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
   initial begin
      mismatches  = 0;
      checks_done = 0;
      sys_rst     = 1'b1;
      global_reset_input        = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      global_reset_input    = 1'b0;
      repeat (4) @(posedge clk_sys);
      foreach (rows[i]) begin
         ofch_host_model_i.access(rows[i].w, rows[i].f, rows[i].a, rows[i].b, rows[i].d, got_k, got_d);
         chk({31'h0, got_k}, {31'h0, rows[i].k});
         chk(got_d, rows[i].r);
      end
      chk({16'h0, cmd}, 32'h0000_0100);
      chk(mft, 32'ha5a5_a5a5);
      chk(lnk, 32'h3c3c_c3c3);
      chk(phy, 32'h6969_9696);
      chk({30'h0, pst}, 32'h3);
      pulse(1'b0, 2);
      chk(lnk, 32'h3c3c_c3c3);
      chk(phy, 32'h6969_9696);
      chk({30'h0, pst}, 32'h3);
      chk({16'h0, cmd}, 32'h0);
      chk(hcc, 32'h0);
      chk(mft, 32'ha5a5_a5a5);
      ofch_host_model_i.access(1'b0, 3'h2, 8'h28, 4'hf, 32'h0, got_k, got_d);
      chk(got_d, 32'h1234_5678);
      pulse(1'b1, 4);
      chk(mft, 32'h0);
      chk(lnk, 32'h0);
      chk(phy, 32'h0);
      chk({30'h0, pst}, 32'h0);
      ofch_host_model_i.access(1'b0, 3'h2, 8'h28, 4'hf, 32'h0, got_k, got_d);
      chk(got_d, 32'h0);
      close_out();
   end
endmodule
